// file: rtl/rwsc_ctrl.sv
// module: supply-low/brownout/watchdog reset sequencing with suspend and wake clock control
//
// Behaviour
// - at power-up use internal oscillator, supply-low reset enabled.
// - after supply rises, wait start-up delay, then run from address zero.
// - enabled supply-low reset repeats the whole sequence on each supply dip.
// - supply-low reset off by disable bit or during suspend; restored after.
// - brownout monitor always active, resets below its trip level.
// - brownout holds reset, re-enables supply-low reset, then start-up delay.
// - supply-low or brownout reset sets the shared cause flag.
// - any write to watchdog clear restarts the watchdog from zero.
// - uncleared watchdog times out, resets and sets cause flag bit 6.
// - watchdog reset held for its duration, then run from address zero.
// - suspend stops oscillators, free-running and watchdog timers.
// - wake only on enabled gpio, wake timer, spi, or low usb minus line.
// - in suspend enabled pending interrupts wake regardless of sense bit.
// - wake condition present at entry still enters suspend, then resumes.
// - after resume execute next instruction before any interrupt.
// - wake clock mode follows external oscillator bit at suspend entry.
// - internal wake: clock within 2 us, then 8 us before release.
// - setting external bit on internal clock halts until stable plus delay.
// - external wake: start oscillator, wait stable, then resume delay.
// - clock configuration bit 3 set disables supply-low reset.
// - supply resets force internal clock; watchdog keeps mode, no start-up delay.
// - external resume delay 128 us if delay bit 0, 4 ms if 1.
`timescale 1ns/1ps
module rwsc_ctrl #(
  parameter int STARTUP_CYC = 12500,
  parameter int WDOG_TIMEOUT_CYC = 1000000,
  parameter int WDOG_RST_CYC = rwsc_pkg::WDOG_RST_CYC,
  parameter int EXT_SHORT_CYC = rwsc_pkg::EXT_SHORT_CYC,
  parameter int EXT_LONG_CYC = rwsc_pkg::EXT_LONG_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analogue monitors and wake sources (asynchronous)
  input wire logic supply_above_thr,
  input wire logic brownout_trip,
  input wire logic ext_osc_stable,
  input wire logic usb_minus_line_pin,
  input wire logic gpio_irq_pend,
  input wire logic wake_tmr_irq_pend,
  input wire logic spi_irq_pend,
  // core control
  output logic core_reset,
  output logic core_run,
  output logic irq_hold,
  output logic int_osc_en,
  output logic ext_osc_en,
  output logic wdog_running
);

  // =========================================
  // input synchronisers
  localparam int NS = 7;
  logic [NS-1:0] async_in;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  assign async_in = {spi_irq_pend, wake_tmr_irq_pend, gpio_irq_pend, usb_minus_line_pin,
                     ext_osc_stable, brownout_trip, supply_above_thr};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  wire supply_ok = sync2_r[0];
  wire bo_trip = sync2_r[1];
  wire osc_stable = sync2_r[2];
  rwsc_pkg::rwsc_wake_s wk;
  assign wk = '{gpio: sync2_r[4], wake_tmr: sync2_r[5], spi: sync2_r[6],
                usb_minus_low: ~sync2_r[3]};

  // =========================================
  // registers
  logic [7:0] status_r;
  logic [7:0] clkcfg_r;
  logic [7:0] wake_en_r;
  logic ext_mode_r;
  logic wake_ext_r;
  logic lvr_armed_r;
  rwsc_pkg::rwsc_state_e state_r;
  rwsc_pkg::rwsc_state_e state_nxt;
  logic [rwsc_pkg::CNT_W-1:0] cnt_r;
  logic [rwsc_pkg::CNT_W-1:0] cnt_nxt;
  logic [rwsc_pkg::CNT_W-1:0] wdog_r;

  // =========================================
  // apb decode: single-cycle access, unmapped reads zero with pslverr
  wire acc = psel & penable;
  wire hit_wdc = paddr == rwsc_pkg::ADDR_WDOG_CLEAR;
  wire hit_st = paddr == rwsc_pkg::ADDR_STATUS;
  wire hit_cc = paddr == rwsc_pkg::ADDR_CLKCFG;
  wire hit_we = paddr == rwsc_pkg::ADDR_WAKE_EN;
  wire mapped = hit_wdc | hit_st | hit_cc | hit_we;
  wire wr = acc & pwrite & (state_r == rwsc_pkg::ST_RUNNING);
  wire wr_wdc = wr & hit_wdc;
  wire wr_st = wr & hit_st;
  wire wr_cc = wr & hit_cc;
  wire wr_we = wr & hit_we;
  wire [31:0] rd_mux = hit_st ? {24'h000000, status_r} :
                       hit_cc ? {24'h000000, clkcfg_r} :
                       hit_we ? {24'h000000, wake_en_r} : rwsc_pkg::APB_ERR_DATA;
  // read data is registered from the setup cycle so it stands during the access cycle
  // watchdog clear is write-only and reads zero
  wire rd_setup = psel & ~penable & ~pwrite & mapped;
  wire [31:0] rd_nxt = rd_setup ? rd_mux : rwsc_pkg::APB_ERR_DATA;

  // =========================================
  // reset, watchdog and wake conditions
  wire in_susp = state_r == rwsc_pkg::ST_SUSP;
  // supply-low reset off by bit 3 or while suspended; brownout always watches
  wire lvr_active = lvr_armed_r & ~clkcfg_r[rwsc_pkg::CC_LVR_DIS] & ~in_susp;
  wire supply_rst = bo_trip | (lvr_active & ~supply_ok);
  wire wdog_to = (state_r == rwsc_pkg::ST_RUNNING) &
                 (wdog_r == rwsc_pkg::CNT_W'(WDOG_TIMEOUT_CYC - 1));
  // interrupt sense bit plays no part here
  wire wake_any = (wk.gpio & wake_en_r[rwsc_pkg::WE_GPIO]) |
                  (wk.wake_tmr & wake_en_r[rwsc_pkg::WE_WAKE_TMR]) |
                  (wk.spi & wake_en_r[rwsc_pkg::WE_SPI]) | wk.usb_minus_low;
  wire susp_req = wr_st & pwdata[rwsc_pkg::ST_SUSPEND] & pwdata[rwsc_pkg::ST_RUN];
  wire ext_req = wr_cc & pwdata[rwsc_pkg::CC_EXT_OSC] & ~ext_mode_r;
  wire [rwsc_pkg::CNT_W-1:0] ext_dly = clkcfg_r[rwsc_pkg::CC_RESUME_DLY] ?
                                       rwsc_pkg::CNT_W'(EXT_LONG_CYC) :
                                       rwsc_pkg::CNT_W'(EXT_SHORT_CYC);
  wire cnt_done = cnt_r == '0;

  // =========================================
  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      rwsc_pkg::ST_POR:
      begin
        // held until supply is above the low threshold
        if (supply_ok & ~bo_trip)
        begin
          state_nxt = rwsc_pkg::ST_STARTUP;
          cnt_nxt = rwsc_pkg::CNT_W'(STARTUP_CYC - 1);
        end
      end
      rwsc_pkg::ST_STARTUP:
        if (cnt_done)
          state_nxt = rwsc_pkg::ST_RUNNING;
      rwsc_pkg::ST_RUNNING:
      begin
        if (wdog_to)
        begin
          state_nxt = rwsc_pkg::ST_WD_HOLD;
          cnt_nxt = rwsc_pkg::CNT_W'(WDOG_RST_CYC - 1);
        end
        else if (susp_req)
          state_nxt = rwsc_pkg::ST_SUSP;
        else if (ext_req)
          state_nxt = rwsc_pkg::ST_OSC_WAIT;
      end
      rwsc_pkg::ST_SUSP:
      begin
        if (wake_any)
        begin
          state_nxt = wake_ext_r ? rwsc_pkg::ST_OSC_WAIT : rwsc_pkg::ST_RESUME;
          cnt_nxt = rwsc_pkg::CNT_W'(rwsc_pkg::INT_START_CYC + rwsc_pkg::INT_DELAY_CYC - 1);
        end
      end
      rwsc_pkg::ST_OSC_WAIT:
      begin
        if (osc_stable)
        begin
          state_nxt = rwsc_pkg::ST_RESUME;
          cnt_nxt = ext_dly - 1'b1;
        end
      end
      rwsc_pkg::ST_RESUME:
        if (cnt_done)
          state_nxt = rwsc_pkg::ST_RUNNING;
      rwsc_pkg::ST_WD_HOLD:
        if (cnt_done)
          state_nxt = rwsc_pkg::ST_RUNNING;
      default:
        state_nxt = rwsc_pkg::ST_POR;
    endcase
    if (supply_rst)
    begin
      state_nxt = rwsc_pkg::ST_POR;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= rwsc_pkg::ST_POR;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // watchdog counts only while running; cleared to zero in suspend and clock switches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdog_r <= '0;
    else if (wr_wdc | state_r != rwsc_pkg::ST_RUNNING)
      wdog_r <= '0;
    else
      wdog_r <= wdog_r + 1'b1;
  end

  // =========================================
  // status, clock configuration and wake enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= rwsc_pkg::STATUS_RST;
      clkcfg_r <= rwsc_pkg::CLKCFG_RST;
      wake_en_r <= rwsc_pkg::WAKE_EN_RST;
      ext_mode_r <= 1'b0;
      wake_ext_r <= 1'b0;
      lvr_armed_r <= 1'b1;
    end
    else if (supply_rst)
    begin
      // supply resets clear config, force internal clock, set the cause flag
      status_r <= rwsc_pkg::STATUS_RST;
      clkcfg_r <= rwsc_pkg::CLKCFG_RST;
      wake_en_r <= rwsc_pkg::WAKE_EN_RST;
      ext_mode_r <= 1'b0;
      wake_ext_r <= 1'b0;
      lvr_armed_r <= 1'b1;
    end
    else if (wdog_to)
    begin
      // clock mode kept; external bit clears but acts only at next suspend
      status_r <= {status_r[7], 1'b1, status_r[5:4], 3'b000, 1'b1};
      clkcfg_r <= rwsc_pkg::CLKCFG_RST;
      wake_en_r <= rwsc_pkg::WAKE_EN_RST;
    end
    else
    begin
      if (wr_st)
        // cause flags are sticky; firmware writes 1 to keep, 0 to clear
        status_r <= {pwdata[7], pwdata[6] & status_r[6], pwdata[5],
                     pwdata[4] & status_r[4], 1'b0, pwdata[2:1], 1'b1};
      if (wr_cc)
        clkcfg_r <= pwdata[7:0];
      if (wr_we)
        wake_en_r <= pwdata[7:0];
      if (susp_req)
        wake_ext_r <= clkcfg_r[rwsc_pkg::CC_EXT_OSC];
      if (ext_req)
        ext_mode_r <= 1'b1;
      else if (state_r == rwsc_pkg::ST_SUSP && wake_any)
        ext_mode_r <= wake_ext_r;
    end
  end

  // =========================================
  // outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      core_reset <= 1'b1;
      core_run <= 1'b0;
      irq_hold <= 1'b0;
      int_osc_en <= 1'b1;
      ext_osc_en <= 1'b0;
      wdog_running <= 1'b0;
    end
    else
    begin
      prdata <= rd_nxt;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == rwsc_pkg::ADDR_WDOG_CLEAR |
                 paddr == rwsc_pkg::ADDR_STATUS | paddr == rwsc_pkg::ADDR_CLKCFG |
                 paddr == rwsc_pkg::ADDR_WAKE_EN);
      core_reset <= state_nxt == rwsc_pkg::ST_POR || state_nxt == rwsc_pkg::ST_STARTUP ||
                    state_nxt == rwsc_pkg::ST_WD_HOLD;
      core_run <= state_nxt == rwsc_pkg::ST_RUNNING;
      irq_hold <= state_nxt == rwsc_pkg::ST_RESUME;
      int_osc_en <= (state_nxt != rwsc_pkg::ST_SUSP) & ~(ext_mode_r | ext_req) |
                    (state_nxt == rwsc_pkg::ST_POR);
      ext_osc_en <= (state_nxt != rwsc_pkg::ST_SUSP) & (state_nxt != rwsc_pkg::ST_POR) &
                    (ext_req | (ext_mode_r & ~(in_susp & ~wake_ext_r)) |
                     (in_susp & wake_ext_r));
      wdog_running <= state_nxt == rwsc_pkg::ST_RUNNING;
    end
  end

  // =========================================
  // checks
  a_wdog_clear_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wr_wdc |=> wdog_r == '0) else $error("watchdog not restarted by clear");
  a_wdog_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_to && !supply_rst |=> status_r[6] && core_reset) else $error("watchdog flag");
  a_supply_flag: assert property (@(posedge pclk) disable iff (!presetn)
    supply_rst |=> status_r[4] && state_r == rwsc_pkg::ST_POR) else $error("supply flag");
  a_brownout_holds: assert property (@(posedge pclk) disable iff (!presetn)
    bo_trip |=> ##1 core_reset) else $error("brownout not holding reset");
  a_lvr_susp_off: assert property (@(posedge pclk) disable iff (!presetn)
    in_susp |-> !lvr_active) else $error("supply-low reset active in suspend");
  a_susp_entry: assert property (@(posedge pclk) disable iff (!presetn)
    susp_req && !wdog_to && !supply_rst |=> in_susp) else $error("suspend not entered");
  a_susp_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
    in_susp && !wake_any && !supply_rst |=> !int_osc_en && !ext_osc_en)
    else $error("oscillator on in suspend");
  a_int_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
    in_susp && wake_any && !wake_ext_r && !supply_rst |=> irq_hold [*8])
    else $error("internal resume too short");
  a_osc_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == rwsc_pkg::ST_OSC_WAIT && !osc_stable |=> !core_run)
    else $error("ran before oscillator stable");
  a_startup_reset: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == rwsc_pkg::ST_STARTUP && !cnt_done |-> ##1 core_reset)
    else $error("released during start-up");

endmodule : rwsc_ctrl

// file: rtl/rwsc_pkg.sv
// package: register map, field positions and timing constants of the reset/suspend controller
package rwsc_pkg;

  // =========================================
  // register map (byte addresses on apb)
  localparam logic [11:0] WDOG_CLEAR_IDX = 12'h026;
  localparam logic [11:0] ADDR_WDOG_CLEAR = 12'h098;
  localparam logic [11:0] ADDR_STATUS = 12'h100;
  localparam logic [11:0] ADDR_CLKCFG = 12'h104;
  localparam logic [11:0] ADDR_WAKE_EN = 12'h108;

  // =========================================
  // field positions
  localparam int ST_RUN = 0;
  localparam int ST_IRQ_SENSE = 2;
  localparam int ST_SUSPEND = 3;
  localparam int ST_SUPPLY_FLAG = 4;
  localparam int ST_WDOG_FLAG = 6;
  localparam int CC_EXT_OSC = 0;
  localparam int CC_RESUME_DLY = 7;
  localparam int CC_LVR_DIS = 3;
  localparam int WE_GPIO = 0;
  localparam int WE_WAKE_TMR = 1;
  localparam int WE_SPI = 2;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h11;
  localparam logic [7:0] CLKCFG_RST = 8'h00;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  localparam logic [31:0] APB_ERR_DATA = 32'h00000000;

  // =========================================
  // timing, in ns and derived cycles at 125 mhz
  localparam int CLK_NS = 8;
  localparam int INT_START_NS = 2000;
  localparam int INT_DELAY_NS = 8000;
  localparam int EXT_SHORT_NS = 128000;
  localparam int EXT_LONG_NS = 4000000;
  localparam int WDOG_RST_NS = 2000000;
  localparam int INT_START_CYC = INT_START_NS / CLK_NS;
  localparam int INT_DELAY_CYC = (INT_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_SHORT_CYC = (EXT_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_LONG_CYC = (EXT_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int WDOG_RST_CYC = (WDOG_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_STARTUP = 3'b001,
    ST_RUNNING = 3'b011,
    ST_SUSP = 3'b010,
    ST_OSC_WAIT = 3'b110,
    ST_RESUME = 3'b111,
    ST_WD_HOLD = 3'b101
  } rwsc_state_e;

  typedef struct packed {
    logic gpio;
    logic wake_tmr;
    logic spi;
    logic usb_minus_low;
  } rwsc_wake_s;

endpackage : rwsc_pkg

// file: tb/rwsc_fw_model.sv
// partner model: firmware side that issues apb transfers to the controller
`timescale 1ns/1ps
module rwsc_fw_model (
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // =========================================
  // one transfer; answer taken at the rising edge where pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // run bit always goes with suspend, otherwise the controller never enters suspend
  task automatic enter_suspend(input logic [31:0] extra);
    logic [31:0] q;
    logic e;
    xfer(1'b1, rwsc_pkg::ADDR_STATUS, 32'h00000009 | extra, q, e);
  endtask : enter_suspend
endmodule : rwsc_fw_model

// file: tb/rwsc_ctrl_test.sv
// testbench: reset, watchdog, suspend and wake sequencing of the controller
`timescale 1ns/1ps
module rwsc_ctrl_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic supply_above_thr, brownout_trip, ext_osc_stable, usb_minus_line_pin;
  logic gpio_irq_pend, wake_tmr_irq_pend, spi_irq_pend, e;
  logic core_reset, core_run, irq_hold, int_osc_en, ext_osc_en, wdog_running;
  int miscompares = 0;
  int tests_run = 0;
  int c;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} rwsc_row_s;
  rwsc_row_s rows [4];

  rwsc_fw_model fw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rwsc_ctrl #(.STARTUP_CYC(20), .WDOG_TIMEOUT_CYC(50), .WDOG_RST_CYC(10),
    .EXT_LONG_CYC(16)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_above_thr(supply_above_thr), .brownout_trip(brownout_trip),
    .ext_osc_stable(ext_osc_stable), .usb_minus_line_pin(usb_minus_line_pin),
    .gpio_irq_pend(gpio_irq_pend), .wake_tmr_irq_pend(wake_tmr_irq_pend),
    .spi_irq_pend(spi_irq_pend), .core_reset(core_reset), .core_run(core_run),
    .irq_hold(irq_hold), .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en),
    .wdog_running(wdog_running));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // =========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait on a design output, c returns the cycles spent
  task automatic wt(ref logic s, input logic v, input int n);
    c = 0;
    while (s !== v && c < n)
    begin
      @(negedge pclk);
      c++;
    end
    chk(s, v);
  endtask : wt

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fw.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic x);
    fw.xfer(1'b0, a, 32'h00000000, q, e);
    chk(q, d);
    chk(e, x);
  endtask : rd

  task automatic close_out;
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  initial
  begin
    #400000;
    miscompares++;
    close_out();
  end

  // =========================================
  // main sequence
  initial
  begin
    rows[0] = '{rwsc_pkg::ADDR_STATUS, 32'h00000011, 1'b0};
    rows[1] = '{rwsc_pkg::ADDR_CLKCFG, 32'h00000000, 1'b0};
    rows[2] = '{rwsc_pkg::ADDR_WAKE_EN, 32'h00000000, 1'b0};
    rows[3] = '{12'h0fc, rwsc_pkg::APB_ERR_DATA, 1'b1};
    presetn = 1'b0;
    supply_above_thr = 1'b1;
    brownout_trip = 1'b0;
    ext_osc_stable = 1'b0;
    usb_minus_line_pin = 1'b1;
    gpio_irq_pend = 1'b0;
    wake_tmr_irq_pend = 1'b0;
    spi_irq_pend = 1'b0;
    repeat (12) @(posedge pclk);
    chk(core_reset, 1'b1);
    chk(int_osc_en, 1'b1);
    presetn <= 1'b1;
    wt(core_run, 1'b1, 100);
    chk(c >= 20, 1'b1);
    foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].e);
    // clears of any value keep the watchdog from firing
    for (int i = 0; i < 20; i++)
    begin
      wr(rwsc_pkg::ADDR_WDOG_CLEAR, i * 37);
      chk(core_reset, 1'b0);
    end
    wt(core_reset, 1'b1, 60);
    wt(core_run, 1'b1, 40);
    chk(c >= 10, 1'b1);
    chk(int_osc_en, 1'b1);
    rd(rwsc_pkg::ADDR_STATUS, 32'h00000051, 1'b0);
    wr(rwsc_pkg::ADDR_STATUS, 32'h00000001);
    wr(rwsc_pkg::ADDR_WAKE_EN, 32'h00000002);
    fw.enter_suspend(32'h00000004);
    wt(core_run, 1'b0, 10);
    chk(int_osc_en, 1'b0);
    chk(wdog_running, 1'b0);
    @(posedge pclk) spi_irq_pend <= 1'b1;
    gpio_irq_pend <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(core_run, 1'b0);
    chk(ext_osc_en, 1'b0);
    wake_tmr_irq_pend <= 1'b1;
    wt(irq_hold, 1'b1, 20);
    wt(core_run, 1'b1, 2000);
    chk(c >= 1200, 1'b1);
    // wake condition already pending at entry
    fw.enter_suspend(32'h00000000);
    wt(core_run, 1'b0, 10);
    wt(core_run, 1'b1, 2000);
    @(posedge pclk) gpio_irq_pend <= 1'b0;
    spi_irq_pend <= 1'b0;
    wake_tmr_irq_pend <= 1'b0;
    wr(rwsc_pkg::ADDR_CLKCFG, 32'h00000081);
    wt(ext_osc_en, 1'b1, 10);
    repeat (30) @(posedge pclk);
    chk(core_run, 1'b0);
    ext_osc_stable <= 1'b1;
    wt(core_run, 1'b1, 100);
    chk(c >= 16, 1'b1);
    fw.enter_suspend(32'h00000000);
    wt(core_run, 1'b0, 10);
    @(posedge pclk) ext_osc_stable <= 1'b0;
    usb_minus_line_pin <= 1'b0;
    wt(ext_osc_en, 1'b1, 20);
    @(posedge pclk) ext_osc_stable <= 1'b1;
    usb_minus_line_pin <= 1'b1;
    wt(core_run, 1'b1, 100);
    chk(c >= 16, 1'b1);
    @(posedge pclk) supply_above_thr <= 1'b0;
    wt(core_reset, 1'b1, 10);
    @(posedge pclk) supply_above_thr <= 1'b1;
    wt(core_run, 1'b1, 60);
    chk(ext_osc_en, 1'b0);
    wr(rwsc_pkg::ADDR_CLKCFG, 32'h00000008);
    @(posedge pclk) supply_above_thr <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(core_reset, 1'b0);
    supply_above_thr <= 1'b1;
    brownout_trip <= 1'b1;
    wt(core_reset, 1'b1, 10);
    @(posedge pclk) brownout_trip <= 1'b0;
    wt(core_run, 1'b1, 60);
    rd(rwsc_pkg::ADDR_CLKCFG, 32'h00000000, 1'b0);
    rd(rwsc_pkg::ADDR_STATUS, 32'h00000011, 1'b0);
    @(posedge pclk) supply_above_thr <= 1'b0;
    wt(core_reset, 1'b1, 10);
    @(posedge pclk) supply_above_thr <= 1'b1;
    presetn <= 1'b0;
    @(negedge pclk);
    chk(core_reset, 1'b1);
    chk(core_run, 1'b0);
    @(posedge pclk) presetn <= 1'b1;
    wt(core_run, 1'b1, 100);
    close_out();
  end
endmodule : rwsc_ctrl_test
